// ==== rtl/apc_synth_ctrl.sv ====
/*
  Control and status logic of the integer-N sample clock synthesizer: divider,
  pump and filter settings, enables, clock source and gating, calibration
  sequencing, drift status and interrupt.
  Assumes a plain register port on clk and asynchronous analog status pins.
*/
// The plain strobed port was decided locally.
// How it works
// RULE1 - a one in the clock source bit selects the synthesizer as the sample clock origin.
// RULE2 - the reference ratio is a ten-bit field whose legal values run from 1 to 1023.
// RULE3 - the feedback ratio is a twelve-bit field whose legal values run from 1 to 4095.
// RULE4 - software picks the two ratios so the oscillator lands in its tuning range.
// RULE5 - a four-bit output ratio divides the oscillator down to the sample clock.
// RULE6 - software keeps the reference and divided reference within their limits.
// RULE7 - a four-bit setting sets the charge pump bias current in equal steps.
// RULE8 - one five-bit resistor select and three five-bit capacitor selects shape the filter.
// RULE9 - software recalibrates after changing the input clock or divider registers.
// RULE10 - toggling the trigger bit or leaving soft reset starts a calibration.
// RULE11 - the calibration result is readable as a bit of the status register.
// RULE12 - low and high drift flags are separate readable bits of the status register.
// RULE13 - four enables gate the circuit, reference divider, output and bias.
// RULE14 - the synthesizer clock reaches the converter only while the gate bit is one.
// RULE15 - a three-bit field selects the delay of the output data clock.
// RULE16 - the calibration bit is low while a calibration runs and high once it ends.
// RULE17 - the drift bits follow the oscillator state with no host action.

`include "apc_synth_defines.svh"

module apc_synth_ctrl
  import apc_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire logic [7:0]     reg_addr,
  input  wire logic [7:0]     reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic      [7:0]     reg_rdata,
  input  wire apc_analog_s    analog_status,
  output apc_synth_cfg_s      synth_cfg,
  output logic                sample_clk_from_synth,
  output logic                adc_clk_gate,
  output logic      [2:0]     out_clock_delay_select,
  output logic                soft_reset_active,
  output logic                calib_start,
  output logic                irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // zero is not a legal ratio; the analog divider sees one instead
  function automatic logic [11:0] apc_nonzero(input logic [11:0] v);
    apc_nonzero = (v == 12'h000) ? 12'h001 : v;
  endfunction : apc_nonzero

  function automatic logic apc_hit(input logic [7:0] a, input logic [7:0] ofs);
    apc_hit = (a == ofs);
  endfunction : apc_hit

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic        soft_reset_r;
  logic        clk_src_r;
  logic [9:0]  ref_ratio_r;
  logic [3:0]  out_div_r;
  logic [11:0] fb_ratio_r;
  logic [3:0]  pump_r;
  logic        synth_en_r;
  logic        refdiv_en_r;
  logic        out_en_r;
  logic        bias_en_r;
  logic [4:0]  res_r;
  logic [4:0]  cap1_r;
  logic [4:0]  cap2_r;
  logic [4:0]  cap3_r;
  logic        trig_r;
  logic [2:0]  dly_r;
  logic        gate_r;
  logic [2:0]  irq_en_r;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_clr;
  logic [2:0]  evt;
  logic [2:0]  sync1_r;
  logic [2:0]  sync2_r;
  logic [2:0]  prev_r;
  logic        done_rise;
  logic        low_rise;
  logic        high_rise;
  logic        trig_toggle;
  logic        srst_exit;
  logic        cal_req;
  logic        cal_done_evt;
  logic        cal_ok_r;
  logic        stale_r;
  logic        div_write;
  apc_cal_e    cal_st_r;
  apc_cal_e    cal_st_nxt;
  logic [7:0]  rd_nxt;
  logic [7:0]  rdata_r;
  logic [11:0] ref_nz;

  // ----------------------------------------------------------------
  // analog status synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      prev_r  <= 3'h0;
    end else begin
      sync1_r <= analog_status;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign done_rise = sync2_r[0] & ~prev_r[0];
  assign low_rise  = sync2_r[1] & ~prev_r[1];
  assign high_rise = sync2_r[2] & ~prev_r[2];

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // divider bytes land at once; no shadow, so a half-written ratio is live
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_ratio_r <= `APC_RST_REF_RATIO;
      out_div_r   <= `APC_RST_OUT_DIV;
      fb_ratio_r  <= `APC_RST_FB_RATIO;
    end else if (reg_wr) begin
      if (apc_hit(reg_addr, `APC_OFS_REF_LO)) begin
        ref_ratio_r[7:0] <= reg_wdata; // RULE2
      end
      if (apc_hit(reg_addr, `APC_OFS_REF_HI)) begin
        ref_ratio_r[9:8] <= reg_wdata[1:0]; // RULE2
        out_div_r <= reg_wdata[`APC_OUTDIV_LSB +: 4]; // RULE5
      end
      if (apc_hit(reg_addr, `APC_OFS_FB_LO)) begin
        fb_ratio_r[7:0] <= reg_wdata; // RULE3
      end
      if (apc_hit(reg_addr, `APC_OFS_FB_HI)) begin
        fb_ratio_r[11:8] <= reg_wdata[3:0]; // RULE3
      end
    end
  end

  // charge pump and loop filter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pump_r <= `APC_RST_PUMP;
      res_r  <= `APC_RST_RES;
      cap1_r <= `APC_RST_CAP1;
      cap2_r <= `APC_RST_CAP2;
      cap3_r <= `APC_RST_CAP3;
    end else if (reg_wr) begin
      if (apc_hit(reg_addr, `APC_OFS_PUMP)) begin
        pump_r <= reg_wdata[3:0]; // RULE7
      end
      if (apc_hit(reg_addr, `APC_OFS_RES)) begin
        res_r <= reg_wdata[4:0]; // RULE8
      end
      if (apc_hit(reg_addr, `APC_OFS_CAP3)) begin
        cap3_r <= reg_wdata[4:0]; // RULE8
      end
      if (apc_hit(reg_addr, `APC_OFS_CAP1)) begin
        cap1_r <= reg_wdata[4:0]; // RULE8
      end
      if (apc_hit(reg_addr, `APC_OFS_CAP2)) begin
        cap2_r <= reg_wdata[4:0]; // RULE8
      end
    end
  end

  // enables, clock source, gate, trigger and interrupt enable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      soft_reset_r <= 1'b0;
      clk_src_r    <= 1'b0;
      synth_en_r   <= 1'b0;
      refdiv_en_r  <= 1'b0;
      out_en_r     <= 1'b0;
      bias_en_r    <= 1'b0;
      trig_r       <= 1'b0;
      dly_r        <= 3'h0;
      gate_r       <= 1'b0;
      irq_en_r     <= 3'h0;
    end else if (reg_wr) begin
      if (apc_hit(reg_addr, `APC_OFS_SOFT_RST)) begin
        soft_reset_r <= reg_wdata[0];
      end
      if (apc_hit(reg_addr, `APC_OFS_CLK_SRC)) begin
        clk_src_r <= reg_wdata[0]; // RULE1
      end
      if (apc_hit(reg_addr, `APC_OFS_SYNTH_EN)) begin
        synth_en_r  <= reg_wdata[`APC_EN_SYNTH_BIT]; // RULE13
        refdiv_en_r <= reg_wdata[`APC_EN_REFDIV_BIT]; // RULE13
      end
      if (apc_hit(reg_addr, `APC_OFS_OUT_EN)) begin
        out_en_r  <= reg_wdata[`APC_EN_OUT_BIT]; // RULE13
        bias_en_r <= reg_wdata[`APC_EN_BIAS_BIT]; // RULE13
      end
      if (apc_hit(reg_addr, `APC_OFS_CAL_TRIG)) begin
        trig_r <= reg_wdata[0];
      end
      if (apc_hit(reg_addr, `APC_OFS_GATE_DLY)) begin
        dly_r  <= reg_wdata[2:0]; // RULE15
        gate_r <= reg_wdata[`APC_GATE_BIT]; // RULE14
      end
      if (apc_hit(reg_addr, `APC_OFS_IRQ_EN)) begin
        irq_en_r <= reg_wdata[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // calibration requests
  // ----------------------------------------------------------------
  // a toggle is any write that flips the stored bit, either way
  assign trig_toggle = reg_wr && apc_hit(reg_addr, `APC_OFS_CAL_TRIG)
                       && (reg_wdata[0] != trig_r); // RULE10
  assign srst_exit   = reg_wr && apc_hit(reg_addr, `APC_OFS_SOFT_RST)
                       && soft_reset_r && !reg_wdata[0]; // RULE10
  assign cal_req     = trig_toggle | srst_exit;
  assign div_write   = reg_wr && (reg_addr >= `APC_OFS_REF_LO)
                       && (reg_addr <= `APC_OFS_FB_HI);

  // ----------------------------------------------------------------
  // calibration sequencer
  // ----------------------------------------------------------------
  // a new request while waiting restarts the run rather than being lost
  always_comb begin
    cal_st_nxt = cal_st_r;
    case (cal_st_r)
      CAL_IDLE: begin
        if (cal_req) begin
          cal_st_nxt = CAL_START;
        end
      end
      CAL_START: begin
        cal_st_nxt = CAL_WAIT;
      end
      CAL_WAIT: begin
        if (cal_req) begin
          cal_st_nxt = CAL_START;
        end else if (done_rise) begin
          cal_st_nxt = CAL_IDLE;
        end
      end
      default: begin
        cal_st_nxt = CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_st_r <= CAL_IDLE;
    end else begin
      cal_st_r <= cal_st_nxt; // RULE10
    end
  end

  assign cal_done_evt = (cal_st_r == CAL_WAIT) && done_rise && !cal_req;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_ok_r <= 1'b0;
    end else if (cal_st_r == CAL_START) begin
      cal_ok_r <= 1'b0; // RULE16
    end else if (cal_done_evt) begin
      cal_ok_r <= 1'b1; // RULE16
    end
  end

  // marks divider register writes since the last calibration start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stale_r <= 1'b0;
    end else if (div_write) begin
      stale_r <= 1'b1; // RULE9
    end else if (cal_st_r == CAL_START) begin
      stale_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  assign evt     = {high_rise, low_rise, cal_done_evt};
  assign irq_clr = (reg_wr && apc_hit(reg_addr, `APC_OFS_IRQ_CLR)) ? reg_wdata[2:0] : 3'h0;

  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_r <= 3'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | evt;
    end
  end

  assign irq = |(irq_stat_r & irq_en_r);

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always_comb begin
    rd_nxt = 8'h00;
    case (reg_addr)
      `APC_OFS_SOFT_RST: rd_nxt = {7'h00, soft_reset_r};
      `APC_OFS_CLK_SRC:  rd_nxt = {7'h00, clk_src_r};
      `APC_OFS_REF_LO:   rd_nxt = ref_ratio_r[7:0];
      `APC_OFS_REF_HI:   rd_nxt = {2'h0, out_div_r, ref_ratio_r[9:8]};
      `APC_OFS_FB_LO:    rd_nxt = fb_ratio_r[7:0];
      `APC_OFS_FB_HI:    rd_nxt = {4'h0, fb_ratio_r[11:8]};
      `APC_OFS_PUMP:     rd_nxt = {4'h0, pump_r};
      `APC_OFS_SYNTH_EN: rd_nxt = {6'h00, refdiv_en_r, synth_en_r};
      `APC_OFS_RES:      rd_nxt = {3'h0, res_r};
      `APC_OFS_CAP3:     rd_nxt = {3'h0, cap3_r};
      `APC_OFS_CAP1:     rd_nxt = {3'h0, cap1_r};
      `APC_OFS_CAP2:     rd_nxt = {3'h0, cap2_r};
      `APC_OFS_OUT_EN:   rd_nxt = {6'h00, bias_en_r, out_en_r};
      `APC_OFS_CAL_TRIG: rd_nxt = {7'h00, trig_r};
      `APC_OFS_GATE_DLY: rd_nxt = {4'h0, gate_r, dly_r};
      `APC_OFS_STATUS: begin
        rd_nxt[`APC_ST_CAL_OK]     = cal_ok_r; // RULE11
        rd_nxt[`APC_ST_LOW_DRIFT]  = sync2_r[1]; // RULE12
        rd_nxt[`APC_ST_HIGH_DRIFT] = sync2_r[2]; // RULE17
        rd_nxt[`APC_ST_CAL_BUSY]   = (cal_st_r != CAL_IDLE);
        rd_nxt[`APC_ST_STALE]      = stale_r;
      end
      `APC_OFS_IRQ_STAT: rd_nxt = {5'h00, irq_stat_r};
      `APC_OFS_IRQ_EN:   rd_nxt = {5'h00, irq_en_r};
      default:           rd_nxt = 8'h00;
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rd_nxt : 8'h00;
    end
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // outputs to the analog synthesizer and clock tree
  // ----------------------------------------------------------------
  assign ref_nz = apc_nonzero({2'h0, ref_ratio_r}); // RULE2

  always_comb begin
    synth_cfg.ref_divide_ratio        = ref_nz[9:0]; // RULE2
    synth_cfg.feedback_ratio          = apc_nonzero(fb_ratio_r); // RULE3
    synth_cfg.output_divide_ratio     = out_div_r; // RULE5
    synth_cfg.pump_current_setting    = pump_r; // RULE7
    synth_cfg.filter_resistor_select  = res_r; // RULE8
    synth_cfg.filter_cap_one_select   = cap1_r;
    synth_cfg.filter_cap_two_select   = cap2_r;
    synth_cfg.filter_cap_three_select = cap3_r;
    synth_cfg.synth_enable            = synth_en_r; // RULE13
    synth_cfg.ref_divider_enable      = refdiv_en_r;
    synth_cfg.synth_out_enable        = out_en_r;
    synth_cfg.synth_bias_enable       = bias_en_r;
  end

  assign sample_clk_from_synth  = clk_src_r; // RULE1
  // clock itself is gated in the analog tree; only the enable lives here
  assign adc_clk_gate           = gate_r; // RULE14
  assign out_clock_delay_select = dly_r; // RULE15
  assign soft_reset_active      = soft_reset_r;
  assign calib_start            = (cal_st_r == CAL_START); // RULE10

endmodule : apc_synth_ctrl

// ==== rtl/apc_synth_defines.svh ====
/*
  Register offsets, field positions and reset values of the synthesizer control block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef APC_SYNTH_DEFINES_SVH
`define APC_SYNTH_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define APC_OFS_SOFT_RST   8'h00
`define APC_OFS_CLK_SRC    8'h53
`define APC_OFS_REF_LO     8'h54
`define APC_OFS_REF_HI     8'h55
`define APC_OFS_FB_LO      8'h56
`define APC_OFS_FB_HI      8'h57
`define APC_OFS_PUMP       8'h58
`define APC_OFS_SYNTH_EN   8'h59
`define APC_OFS_RES        8'h5a
`define APC_OFS_CAP3       8'h5b
`define APC_OFS_CAP1       8'h5c
`define APC_OFS_CAP2       8'h5d
`define APC_OFS_OUT_EN     8'h5f
`define APC_OFS_CAL_TRIG   8'h6b
`define APC_OFS_GATE_DLY   8'h6d
`define APC_OFS_STATUS     8'hd1
`define APC_OFS_IRQ_STAT   8'he0
`define APC_OFS_IRQ_EN     8'he1
`define APC_OFS_IRQ_CLR    8'he2

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define APC_OUTDIV_LSB     2
`define APC_EN_SYNTH_BIT   0
`define APC_EN_REFDIV_BIT  1
`define APC_EN_OUT_BIT     0
`define APC_EN_BIAS_BIT    1
`define APC_GATE_BIT       3
`define APC_ST_CAL_OK      0
`define APC_ST_LOW_DRIFT   1
`define APC_ST_HIGH_DRIFT  2
`define APC_ST_CAL_BUSY    3
`define APC_ST_STALE       4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define APC_RST_REF_RATIO  10'h00a
`define APC_RST_FB_RATIO   12'h078
`define APC_RST_OUT_DIV    4'h6
`define APC_RST_PUMP       4'h4
`define APC_RST_RES        5'h1f
`define APC_RST_CAP3       5'h02
`define APC_RST_CAP1       5'h01
`define APC_RST_CAP2       5'h01

`endif

// ==== rtl/apc_pkg.sv ====
/*
  Types of the synthesizer control block: calibration states and signal bundles.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package apc_pkg;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_START,
    CAL_WAIT
  } apc_cal_e;

  // settings driven into the analog synthesizer
  typedef struct packed {
    logic [9:0]  ref_divide_ratio;
    logic [11:0] feedback_ratio;
    logic [3:0]  output_divide_ratio;
    logic [3:0]  pump_current_setting;
    logic [4:0]  filter_resistor_select;
    logic [4:0]  filter_cap_one_select;
    logic [4:0]  filter_cap_two_select;
    logic [4:0]  filter_cap_three_select;
    logic        synth_enable;
    logic        ref_divider_enable;
    logic        synth_out_enable;
    logic        synth_bias_enable;
  } apc_synth_cfg_s;

  // raw status pins from the analog synthesizer
  typedef struct packed {
    logic osc_high_drift;
    logic osc_low_drift;
    logic calib_done;
  } apc_analog_s;

endpackage : apc_pkg

// ==== tb/apc_synth_monitor.sv ====
/*
  Port checker of the synthesizer control block.
  Assumes a bind onto apc_synth_ctrl, one clock and the async low reset.
*/
module apc_synth_monitor
  import apc_pkg::*;
(
  input wire logic           clk,
  input wire logic           reset_n,
  input wire logic [7:0]     reg_addr,
  input wire logic [7:0]     reg_wdata,
  input wire logic           reg_wr,
  input wire logic           reg_rd,
  input wire logic [7:0]     reg_rdata,
  input wire apc_synth_cfg_s synth_cfg,
  input wire logic           sample_clk_from_synth,
  input wire logic           adc_clk_gate,
  input wire logic [2:0]     out_clock_delay_select,
  input wire logic           soft_reset_active,
  input wire logic           calib_start
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic       trig_r;
  logic [7:0] wd_r;

  // mirror of the trigger bit, so a toggle can be told from a rewrite
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_r <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h6b) begin
      trig_r <= reg_wdata[0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wd_r <= 8'h00;
    end else begin
      wd_r <= reg_wdata;
    end
  end

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_cal_toggle: assert property (reg_wr && reg_addr == 8'h6b && reg_wdata[0] != trig_r
    |=> calib_start ##1 !calib_start) else $error("trigger toggle gave no start pulse");
  a_cal_cause: assert property (calib_start |-> $past(reg_wr)
    && ($past(reg_addr) == 8'h6b || $past(reg_addr) == 8'h00)) else $error("start without cause");
  a_softrst_cal: assert property (soft_reset_active && reg_wr && reg_addr == 8'h00
    && !reg_wdata[0] |=> calib_start) else $error("soft reset exit gave no start");
  a_src_write: assert property (reg_wr && reg_addr == 8'h53
    |=> sample_clk_from_synth == wd_r[0]) else $error("clock source not taken");
  a_gate_write: assert property (reg_wr && reg_addr == 8'h6d
    |=> adc_clk_gate == wd_r[3] && out_clock_delay_select == wd_r[2:0])
    else $error("gate or delay not taken");
  a_pump_write: assert property (reg_wr && reg_addr == 8'h58
    |=> synth_cfg.pump_current_setting == wd_r[3:0]) else $error("pump setting not taken");
  a_enable_write: assert property (reg_wr && reg_addr == 8'h59
    |=> synth_cfg.synth_enable == wd_r[0] && synth_cfg.ref_divider_enable == wd_r[1])
    else $error("enables not taken");
  a_ratio_legal: assert property (synth_cfg.ref_divide_ratio != 10'h000
    && synth_cfg.feedback_ratio != 12'h000) else $error("zero divide ratio driven");
  a_cfg_hold: assert property (!reg_wr |=> $stable({synth_cfg, sample_clk_from_synth,
    adc_clk_gate, out_clock_delay_select})) else $error("settings moved without write");
endmodule : apc_synth_monitor

bind apc_synth_ctrl apc_synth_monitor u_apc_synth_monitor (
  .clk                    (clk),
  .reset_n                (reset_n),
  .reg_addr               (reg_addr),
  .reg_wdata              (reg_wdata),
  .reg_wr                 (reg_wr),
  .reg_rd                 (reg_rd),
  .reg_rdata              (reg_rdata),
  .synth_cfg              (synth_cfg),
  .sample_clk_from_synth  (sample_clk_from_synth),
  .adc_clk_gate           (adc_clk_gate),
  .out_clock_delay_select (out_clock_delay_select),
  .soft_reset_active      (soft_reset_active),
  .calib_start            (calib_start)
);

// ==== tb/apc_analog_model.sv ====
/*
  Behavioural analog synthesizer status pins.
  Assumes calib_start as a one-cycle pulse; delay and drift come from the bench.
*/
module apc_analog_model
  import apc_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset_n,
  input  wire logic  calib_start,
  input  wire logic  [3:0] cal_delay,
  input  wire logic  drift_lo,
  input  wire logic  drift_hi,
  output apc_analog_s analog_status
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt_r;
  logic       done_r;

  // a new start drops done at once, so a restart never sees a stale finish
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r  <= 4'h0;
      done_r <= 1'b0;
    end else if (calib_start) begin
      cnt_r  <= cal_delay;
      done_r <= 1'b0;
    end else if (cnt_r != 4'h0) begin
      cnt_r  <= cnt_r - 4'h1;
      done_r <= (cnt_r == 4'h1);
    end
  end

  assign analog_status = {drift_hi, drift_lo, done_r};
endmodule : apc_analog_model

// ==== tb/tb.sv ====
/*
  Self-checking bench of the synthesizer control block.
  Assumes the register port contract and the analog model beside it.
*/
module tb
  import apc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic           clk = 1'b0;
  logic           reset_n;
  logic           reg_wr;
  logic           reg_rd;
  logic [7:0]     reg_addr;
  logic [7:0]     reg_wdata;
  logic [7:0]     reg_rdata;
  apc_analog_s    analog_status;
  apc_synth_cfg_s cfg;
  logic           src;
  logic           gate;
  logic [2:0]     dly;
  logic           srst;
  logic           cstart;
  logic           irq;
  logic [3:0]     cal_delay;
  logic           drift_lo;
  logic           drift_hi;
  int             err_total;
  int             cmp_count;
  int             starts;

  always #5 clk = ~clk;

  apc_synth_ctrl u_apc_synth_ctrl (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .analog_status(analog_status), .synth_cfg(cfg), .sample_clk_from_synth(src),
    .adc_clk_gate(gate), .out_clock_delay_select(dly), .soft_reset_active(srst),
    .calib_start(cstart), .irq(irq));

  apc_analog_model u_apc_analog_model (
    .clk(clk), .reset_n(reset_n), .calib_start(cstart), .cal_delay(cal_delay),
    .drift_lo(drift_lo), .drift_hi(drift_hi), .analog_status(analog_status));

  always @(posedge clk) begin
    if (cstart === 1'b1) begin
      starts <= starts + 1;
    end
  end

  // ----------------------------------------------------------------
  // bus cycles and comparison
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(32'(reg_rdata), 32'(e));
    @(posedge clk);
  endtask : rd

  // done pin plus the synchroniser lag
  task automatic wait_cal;
    for (int i = 0; i < 60 && analog_status.calib_done !== 1'b1; i++) begin
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : wait_cal

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(32'({cfg.ref_divide_ratio, cfg.feedback_ratio}), {10'h00a, 12'h078});
    chk(32'({cfg.output_divide_ratio, cfg.pump_current_setting}), 32'h64);
    chk(32'({cfg.filter_resistor_select, cfg.filter_cap_one_select, cfg.filter_cap_two_select,
      cfg.filter_cap_three_select}), {5'h1f, 5'h01, 5'h01, 5'h02});
    chk(32'({src, gate, dly, srst, cstart, irq}), 32'h0);
    rd(8'hd1, 8'h00);
  endtask : t_reset

  task automatic t_div;
    wr(8'h54, 8'hff);
    wr(8'h55, 8'h3f);
    wr(8'h56, 8'hff);
    wr(8'h57, 8'h0f);
    chk(32'({cfg.ref_divide_ratio, cfg.feedback_ratio}), {10'h3ff, 12'hfff});
    chk(32'(cfg.output_divide_ratio), 32'hf);
    rd(8'h55, 8'h3f);
    wr(8'h54, 8'h00);
    wr(8'h55, 8'h18);
    chk(32'(cfg.ref_divide_ratio), 32'h1);
    rd(8'h54, 8'h00);
    rd(8'hd1, 8'h10);
    wr(8'h54, 8'h0a);
    wr(8'h56, 8'h78);
    wr(8'h57, 8'h00);
    chk(32'(cfg.feedback_ratio), 32'h78);
  endtask : t_div

  task automatic t_filter;
    wr(8'h58, 8'h0f);
    wr(8'h5a, 8'h15);
    wr(8'h5b, 8'h0b);
    wr(8'h5c, 8'h1e);
    wr(8'h5d, 8'h03);
    chk(32'({cfg.pump_current_setting, cfg.filter_resistor_select, cfg.filter_cap_one_select,
      cfg.filter_cap_two_select, cfg.filter_cap_three_select}),
      32'({4'hf, 5'h15, 5'h1e, 5'h03, 5'h0b}));
    rd(8'h5b, 8'h0b);
  endtask : t_filter

  task automatic t_enable;
    wr(8'h53, 8'h01);
    wr(8'h59, 8'h03);
    wr(8'h5f, 8'h03);
    wr(8'h6d, 8'h0f);
    chk(32'({src, cfg.synth_enable, cfg.ref_divider_enable, cfg.synth_out_enable,
      cfg.synth_bias_enable, gate, dly}), 32'h1ff);
    wr(8'h6d, 8'h05);
    wr(8'h5f, 8'h02);
    chk(32'({cfg.synth_out_enable, cfg.synth_bias_enable, gate, dly}), 32'h15);
  endtask : t_enable

  task automatic t_calib;
    cal_delay <= 4'h3;
    wr(8'he1, 8'h00);
    wr(8'h6b, 8'h01);
    #1 chk(32'(starts), 32'h1);
    rd(8'hd1, 8'h08);
    wait_cal();
    chk(32'(irq), 32'h0);
    rd(8'hd1, 8'h01);
    rd(8'he0, 8'h01);
    wr(8'he1, 8'h01);
    chk(32'(irq), 32'h1);
    wr(8'he2, 8'h01);
    chk(32'(irq), 32'h0);
    wr(8'h6b, 8'h01);
    #1 chk(32'(starts), 32'h1);
  endtask : t_calib

  task automatic t_softrst;
    cal_delay <= 4'hc;
    wr(8'h00, 8'h01);
    chk(32'(srst), 32'h1);
    wr(8'h00, 8'h00);
    #1 chk(32'(starts), 32'h2);
    rd(8'hd1, 8'h08);
    wait_cal();
    rd(8'hd1, 8'h01);
    wr(8'he2, 8'h01);
  endtask : t_softrst

  task automatic t_drift;
    wr(8'he1, 8'h07);
    drift_lo <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'hd1, 8'h03);
    chk(32'(irq), 32'h1);
    rd(8'he0, 8'h02);
    wr(8'he2, 8'h02);
    chk(32'(irq), 32'h0);
    drift_lo <= 1'b0;
    drift_hi <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'hd1, 8'h05);
    rd(8'he0, 8'h04);
    wr(8'hd1, 8'hff);
    rd(8'hd1, 8'h05);
    rd(8'he2, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'he2, 8'h07);
    chk(32'(irq), 32'h0);
  endtask : t_drift

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #100us;
    err_total++;
    tally_and_finish();
  end

  initial begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, drift_lo, drift_hi} = '0;
    {err_total, cmp_count, starts} = '0;
    cal_delay = 4'h5;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1 t_reset();
    t_div();
    t_filter();
    t_enable();
    t_calib();
    t_softrst();
    t_drift();
    tally_and_finish();
  end
endmodule : tb
